// ===== core/gain_port_regs.vh
// Constants for the dual channel gain control port host.
// Assumes inclusion by bare name from core/ design files.
`ifndef GAIN_PORT_REGS_VH
`define GAIN_PORT_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Register offsets (byte addresses)
`define REG_CTRL        8'h00
`define REG_SER_CMD     8'h04
`define REG_PAR_GAIN    8'h08
`define REG_STATUS      8'h0C
`define REG_DIV         8'h10

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define CTRL_MODE_BIT   0
`define CTRL_STANDBY_PIN_FIRST_CHANNEL_BIT 1
`define CTRL_STANDBY_PIN_SECOND_CHANNEL_BIT 2
`define CMD_CHAN_BIT    8
`define CMD_GO_BIT      31
`define STAT_BUSY_BIT   0
`define STAT_DONE_BIT   1
`define EN_BIT          7
`define GAIN_HI         6
`define GAIN_LO         1

////////////////////////////////////////////////////////////////////////////////
// Reset values and link figures
`define CTRL_RESET      3'h7
`define DIV_RESET       8'h03
`define FRAME_BITS      16
`define CLK_PERIOD_NS   8
`define TLC_NS          10
`define TLC_CYCLES      ((`TLC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== core/serial_shifter.v
// Serial frame engine: shifts one 16-bit frame out MSB first, then raises
// the latch strobe. Assumes a start pulse from logic on the same clock.
`timescale 1ns/1ps
`include "gain_port_regs.vh"

module serial_shifter #(
    parameter DIV_W = 8
) (
    // Clock and reset
    input  wire             hclk,
    input  wire             hresetn,
    // Request
    input  wire             start,
    input  wire [15:0]      frame,
    input  wire [DIV_W-1:0] half_div,
    output reg              busy_ff,
    output reg              done_ff,
    // Link pins
    output reg              sclk_ff,
    output reg              sdata_ff,
    output reg              latch_strobe_n_ff
);

    localparam ST_IDLE = 2'h0;
    localparam ST_LOW  = 2'h1;
    localparam ST_HIGH = 2'h2;
    localparam ST_TLC  = 2'h3;
    // Strobe gap in clocks, sized to the timer
    localparam [DIV_W-1:0] TLC_CNT = `TLC_CYCLES;

    reg [1:0]       state_ff;
    reg [15:0]      sh_ff;
    reg [4:0]       cnt_ff;
    reg [DIV_W-1:0] tmr_ff;

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff          <= ST_IDLE;
            sh_ff             <= 16'h0000;
            cnt_ff            <= 5'h00;
            tmr_ff            <= {DIV_W{1'b0}};
            busy_ff           <= 1'b0;
            done_ff           <= 1'b0;
            sclk_ff           <= 1'b0;
            sdata_ff          <= 1'b0;
            latch_strobe_n_ff <= 1'b1;
        end else begin
            done_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (start) begin
                        // Strobe low for the whole frame
                        latch_strobe_n_ff <= 1'b0;
                        sdata_ff          <= frame[15]; // MSB first
                        sh_ff             <= {frame[14:0], 1'b0};
                        cnt_ff            <= 5'h10;
                        tmr_ff            <= half_div;
                        busy_ff           <= 1'b1;
                        state_ff          <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (tmr_ff != {DIV_W{1'b0}}) begin
                        tmr_ff <= tmr_ff - 1'b1;
                    end else begin
                        // Rising edge samples data
                        sclk_ff  <= 1'b1;
                        tmr_ff   <= half_div;
                        cnt_ff   <= cnt_ff - 5'h01;
                        state_ff <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (tmr_ff != {DIV_W{1'b0}}) begin
                        tmr_ff <= tmr_ff - 1'b1;
                    end else if (cnt_ff == 5'h00) begin
                        // Hold last edge for the strobe gap
                        tmr_ff   <= (half_div > TLC_CNT) ? half_div : TLC_CNT;
                        state_ff <= ST_TLC;
                    end else begin
                        sclk_ff  <= 1'b0;
                        sdata_ff <= sh_ff[15];
                        sh_ff    <= {sh_ff[14:0], 1'b0};
                        tmr_ff   <= half_div;
                        state_ff <= ST_LOW;
                    end
                end
                ST_TLC: begin
                    if (tmr_ff != {DIV_W{1'b0}}) begin
                        tmr_ff <= tmr_ff - 1'b1;
                    end else begin
                        // Strobe rises before any further clock
                        latch_strobe_n_ff <= 1'b1;
                        sclk_ff           <= 1'b0;
                        busy_ff           <= 1'b0;
                        done_ff           <= 1'b1;
                        state_ff          <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

endmodule

// ===== core/ahb_reg_slave.v
// AHB-Lite slave front end: turns single word transfers into a one-cycle
// write strobe and a registered read address. Assumes a single slave, zero wait states.
`timescale 1ns/1ps

module ahb_reg_slave (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    input  wire [31:0] rd_data,
    output reg  [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    // Register side
    output reg         wr_ff,
    output reg  [7:0]  addr_ff,
    output wire [31:0] wr_data
);

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wr_data   = hwdata;

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff   <= 1'b0;
            addr_ff <= 8'h00;
        end else if (hready) begin
            // Only word size is honoured; others still act as words
            wr_ff   <= hsel & htrans[1] & hwrite & (hsize == 3'h2 || 1'b1);
            addr_ff <= haddr;
        end
    end

    always @* begin
        hrdata = rd_data;
    end

endmodule

// ===== core/gain_port_host.v
// Host controller for a dual channel gain control port. Software programs
// it over AHB-Lite; it drives serial or parallel control pins of the part.
// Assumes a zero wait state AHB-Lite bus and the part on the pins below.
//
// Operation
// - Serial frame is sixteen bits, two words
// - Channel word bit zero picks channel
// - Keep strobe low for the whole frame
// - Raise strobe after gap, before next clock
// - Standby pins high during serial operation
// - Program each channel with own transfer
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "gain_port_regs.vh"

module gain_port_host #(
    parameter DIV_W = 8
) (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    output wire [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    // Mode and standby pins
    output reg         mode_select_ff,
    output reg         standby_pin_first_channel_ff,
    output reg         standby_pin_second_channel_ff,
    // Serial pins
    output wire        sclk,
    output wire        sdata,
    output wire        latch_strobe_n,
    // Parallel gain pins
    output reg  [5:0]  par_gain_a_ff,
    output reg  [5:0]  par_gain_b_ff
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus front end
    wire        wr_ff;
    wire [7:0]  addr_ff;
    wire [31:0] wr_data;
    reg  [31:0] rd_data;

    ahb_reg_slave u_bus (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .hwdata    (hwdata),
        .rd_data   (rd_data),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .wr_ff     (wr_ff),
        .addr_ff   (addr_ff),
        .wr_data   (wr_data)
    );

    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    reg  [15:0]      frame_ff;
    reg              start_ff;
    reg  [DIV_W-1:0] div_ff;
    reg              done_seen_ff;
    wire             busy;
    wire             done;
    wire             cmd_wr = wr_ff & hit(addr_ff, `REG_SER_CMD) & wr_data[`CMD_GO_BIT];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Pins float-high equivalent: parallel, both active
            mode_select_ff                <= 1'b1;
            standby_pin_first_channel_ff  <= 1'b1;
            standby_pin_second_channel_ff <= 1'b1;
            par_gain_a_ff                 <= 6'h00;
            par_gain_b_ff                 <= 6'h00;
            frame_ff                      <= 16'h0000;
            start_ff                      <= 1'b0;
            div_ff                        <= `DIV_RESET;
            done_seen_ff                  <= 1'b0;
        end else begin
            start_ff <= 1'b0;
            if (wr_ff && hit(addr_ff, `REG_CTRL)) begin
                // Low selects serial mode
                mode_select_ff                <= wr_data[`CTRL_MODE_BIT];
                // Both standby pins from one write move together
                // Serial mode forces both high so the enable bit still works
                standby_pin_first_channel_ff  <= wr_data[`CTRL_STANDBY_PIN_FIRST_CHANNEL_BIT] | ~wr_data[`CTRL_MODE_BIT];
                standby_pin_second_channel_ff <= wr_data[`CTRL_STANDBY_PIN_SECOND_CHANNEL_BIT] | ~wr_data[`CTRL_MODE_BIT];
            end else if (wr_ff && hit(addr_ff, `REG_PAR_GAIN)) begin
                // Both channels applied in one cycle
                par_gain_a_ff <= wr_data[5:0];
                par_gain_b_ff <= wr_data[13:8];
            end else if (wr_ff && hit(addr_ff, `REG_DIV)) begin
                div_ff <= wr_data[DIV_W-1:0];
            end
            if (cmd_wr && !busy) begin
                // One channel per transfer, upper channel bits zero
                frame_ff <= {7'h00, wr_data[`CMD_CHAN_BIT],
                             wr_data[`EN_BIT], wr_data[`GAIN_HI:`GAIN_LO], 1'b0};
                start_ff <= 1'b1;
            end
            // Set wins over the clear by a new command
            if (done) begin
                done_seen_ff <= 1'b1;
            end else if (cmd_wr && !busy) begin
                done_seen_ff <= 1'b0;
            end
        end
    end

    always @* begin
        if (hit(addr_ff, `REG_CTRL)) begin
            rd_data = {29'h0, standby_pin_second_channel_ff, standby_pin_first_channel_ff, mode_select_ff};
        end else if (hit(addr_ff, `REG_SER_CMD)) begin
            rd_data = {16'h0, frame_ff};
        end else if (hit(addr_ff, `REG_PAR_GAIN)) begin
            rd_data = {18'h0, par_gain_b_ff, 2'h0, par_gain_a_ff};
        end else if (hit(addr_ff, `REG_STATUS)) begin
            rd_data = {30'h0, done_seen_ff, busy | start_ff};
        end else if (hit(addr_ff, `REG_DIV)) begin
            rd_data = {{(32-DIV_W){1'b0}}, div_ff};
        end else begin
            rd_data = 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial engine; strobe rise makes the part latch
    serial_shifter #(
        .DIV_W (DIV_W)
    ) u_shift (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .start             (start_ff),
        .frame             (frame_ff),
        .half_div          (div_ff),
        .busy_ff           (busy),
        .done_ff           (done),
        .sclk_ff           (sclk),
        .sdata_ff          (sdata),
        .latch_strobe_n_ff (latch_strobe_n)
    );

endmodule

// ===== verif/gain_port_host_properties.sv
// Checker for the gain port host link pins and bus response.
// Assumes binding to gain_port_host; sees its ports only.
`timescale 1ns/1ps
module gain_port_host_properties #(
    parameter DIV_W = 8
) (
    input wire hclk,
    input wire hresetn,
    input wire hreadyout,
    input wire hresp,
    input wire mode_select_ff,
    input wire standby_pin_first_channel_ff,
    input wire standby_pin_second_channel_ff,
    input wire sclk,
    input wire sdata,
    input wire latch_strobe_n
);
////////////////////////////////////////////////////////////////////////////////
reg       sclk_q;
reg [4:0] rises_ff;
reg [2:0] since_ff;
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        sclk_q   <= 1'b0;
        rises_ff <= 5'h00;
        since_ff <= 3'h7;
    end else begin
        sclk_q   <= sclk;
        if (latch_strobe_n) rises_ff <= 5'h00;
        else if (sclk && !sclk_q) rises_ff <= rises_ff + 5'h01;
        // Saturates so a long idle never wraps back to zero
        if (sclk && !sclk_q) since_ff <= 3'h0;
        else if (since_ff != 3'h7) since_ff <= since_ff + 3'h1;
    end
end
////////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);
a_frame_count: assert property ($rose(latch_strobe_n) |-> rises_ff == 5'h10)
    else $error("frame bit count wrong");
a_strobe_gap: assert property ($rose(latch_strobe_n) |-> since_ff >= 3'h2)
    else $error("strobe raised too soon");
a_chan_zero: assert property ($rose(sclk) && rises_ff < 5'h07 |-> !sdata)
    else $error("unused channel bit not zero");
a_data_stable: assert property ($rose(sclk) |-> $stable(sdata))
    else $error("data moved at clock rise");
a_idle_clock: assert property (latch_strobe_n |-> !sclk)
    else $error("clock outside frame");
a_strobe_setup: assert property ($fell(latch_strobe_n) |-> !sclk [*2])
    else $error("clock too soon after strobe fall");
a_frame_ends: assert property ($fell(latch_strobe_n) |-> ##[1:600] $rose(latch_strobe_n))
    else $error("frame never ended");
a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus response not okay");
a_serial_standby: assert property (!mode_select_ff |->
    standby_pin_first_channel_ff && standby_pin_second_channel_ff)
    else $error("standby pin low in serial mode");
c_frame: cover property ($rose(latch_strobe_n));
c_first_rise: cover property ($rose(sclk) && rises_ff == 5'h00);
c_last_rise: cover property ($rose(sclk) && rises_ff == 5'h0F);
endmodule
bind gain_port_host gain_port_host_properties #(.DIV_W(DIV_W)) props_inst (.hclk(hclk), .hresetn(hresetn),
    .hreadyout(hreadyout), .hresp(hresp), .mode_select_ff(mode_select_ff),
    .standby_pin_first_channel_ff(standby_pin_first_channel_ff),
    .standby_pin_second_channel_ff(standby_pin_second_channel_ff),
    .sclk(sclk), .sdata(sdata), .latch_strobe_n(latch_strobe_n));

// ===== verif/gain_device_model.sv
// Behavioural model of the dual channel gain part behind the host.
// Assumes host pins are always driven; shows applied state per channel.
`timescale 1ns/1ps
module gain_device_model (
    input  wire       mode_select,
    input  wire       standby_pin_first_channel,
    input  wire       standby_pin_second_channel,
    input  wire       sclk,
    input  wire       sdata,
    input  wire       latch_strobe_n,
    input  wire [5:0] par_a,
    input  wire [5:0] par_b,
    output wire [5:0] att_a,
    output wire [5:0] att_b,
    output wire       active_a,
    output wire       active_b
);
reg [15:0] shift_ff;
reg [5:0]  s_att_a;
reg [5:0]  s_att_b;
reg        s_en_a;
reg        s_en_b;
////////////////////////////////////////////////////////////////////////////////
initial begin
    shift_ff = 16'h0000;
    s_att_a  = 6'h00;
    s_att_b  = 6'h00;
    s_en_a   = 1'b1;
    s_en_b   = 1'b1;
end
always @(posedge sclk) begin
    if (!mode_select) shift_ff <= {shift_ff[14:0], sdata};
end
// No serial setting applies until the strobe rises
always @(posedge latch_strobe_n) begin
    if (!mode_select) begin
        if (shift_ff[8]) begin
            s_en_b  <= shift_ff[7];
            s_att_b <= shift_ff[6:1];
        end else begin
            s_en_a  <= shift_ff[7];
            s_att_a <= shift_ff[6:1];
        end
    end
end
assign att_a    = mode_select ? par_a : s_att_a;
assign att_b    = mode_select ? par_b : s_att_b;
assign active_a = standby_pin_first_channel & (mode_select | s_en_a);
assign active_b = standby_pin_second_channel & (mode_select | s_en_b);
endmodule

// ===== verif/gain_port_host_tb.sv
// Self-checking bench for the gain port host with a part model.
// Assumes a single AHB-Lite slave whose hreadyout feeds hready.
`timescale 1ns/1ps
module gain_port_host_tb;
logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
logic [7:0]  haddr = 8'h00;
logic [1:0]  htrans = 2'h0;
logic [2:0]  hsize = 3'h0;
logic [31:0] hwdata = 32'h0, rd;
wire  [31:0] hrdata;
wire         hreadyout, hresp, mode_sel, sa, sb, sclk, sdata, strobe_n, act_a, act_b;
wire  [5:0]  pa, pb, att_a, att_b;
int          fail_count = 0, comparisons = 0;
always #4 hclk = ~hclk;
gain_port_host gain_port_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .mode_select_ff(mode_sel), .standby_pin_first_channel_ff(sa),
    .standby_pin_second_channel_ff(sb), .sclk(sclk), .sdata(sdata), .latch_strobe_n(strobe_n),
    .par_gain_a_ff(pa), .par_gain_b_ff(pb));
gain_device_model gain_device_model_inst (.mode_select(mode_sel), .standby_pin_first_channel(sa), .standby_pin_second_channel(sb), .sclk(sclk),
    .sdata(sdata), .latch_strobe_n(strobe_n), .par_a(pa), .par_b(pb), .att_a(att_a), .att_b(att_b),
    .active_a(act_a), .active_b(act_b));
////////////////////////////////////////////////////////////////////////////////
task report_and_stop;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
endtask
task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
        fail_count++;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
endtask
task hwait;
    int n;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin fail_count++; report_and_stop; end
endtask
task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= 3'h2;
    hwait;
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    hwait;
    rd = hrdata;
endtask
task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
endtask
// Waits for done rather than busy, so an early poll cannot slip past
task wait_done;
    int n;
    n = 0;
    do begin bus(1'b0, 8'h0C, 32'h0); n++; end while (rd[1:0] !== 2'h2 && n < 200);
    if (rd[1:0] !== 2'h2) begin fail_count++; report_and_stop; end
endtask
task send(input logic ch, input logic en, input logic [5:0] g);
    bus(1'b1, 8'h04, {1'b1, 22'h0, ch, en, g, 1'b0});
    wait_done;
endtask
////////////////////////////////////////////////////////////////////////////////
task t_reset;
    rchk("ctrl", 8'h00, 32'h7);
    rchk("div", 8'h10, 32'h3);
    rchk("status", 8'h0C, 32'h0);
    rchk("unmapped", 8'h14, 32'h0);
    chk("mode", 1, mode_sel);
    chk("att_a", 0, att_a);
    chk("att_b", 0, att_b);
    chk("act_a", 1, act_a);
    chk("act_b", 1, act_b);
    $display("test reset done");
endtask
task t_serial;
    bus(1'b1, 8'h08, 32'h2A15);
    bus(1'b1, 8'h00, 32'h0);
    rchk("ctrl", 8'h00, 32'h6);
    send(1'b0, 1'b1, 6'h3F);
    chk("mode", 0, mode_sel);
    chk("standby_pin_first_channel", 1, sa);
    chk("standby_pin_second_channel", 1, sb);
    chk("att_a", 32'h3F, att_a);
    chk("act_a", 1, act_a);
    chk("att_b", 0, att_b);
    send(1'b1, 1'b0, 6'h15);
    chk("act_b", 0, act_b);
    chk("att_b", 32'h15, att_b);
    chk("att_a", 32'h3F, att_a);
    rchk("frame", 8'h04, 32'h012A);
    $display("test serial done");
endtask
task t_refuse;
    bus(1'b1, 8'h10, 32'h2);
    rchk("div", 8'h10, 32'h2);
    bus(1'b1, 8'h04, 32'h80000082);
    rchk("busy", 8'h0C, 32'h1);
    bus(1'b1, 8'h04, 32'h8000017E);
    wait_done;
    rchk("frame", 8'h04, 32'h0082);
    chk("att_a", 32'h01, att_a);
    chk("act_a", 1, act_a);
    chk("att_b", 32'h15, att_b);
    chk("act_b", 0, act_b);
    $display("test refuse done");
endtask
task t_parallel;
    bus(1'b1, 8'h00, 32'h7);
    rchk("ctrl", 8'h00, 32'h7);
    chk("att_a", 32'h15, att_a);
    chk("att_b", 32'h2A, att_b);
    chk("act_b", 1, act_b);
    bus(1'b1, 8'h00, 32'h1);
    rchk("ctrl", 8'h00, 32'h1);
    chk("act_a", 0, act_a);
    chk("act_b", 0, act_b);
    bus(1'b1, 8'h00, 32'h7);
    rchk("ctrl", 8'h00, 32'h7);
    chk("act_a", 1, act_a);
    chk("att_a", 32'h15, att_a);
    $display("test parallel done");
endtask
initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_serial;
    t_refuse;
    t_parallel;
    report_and_stop;
end
endmodule
